// ==== tcp_defines.vh ====
// constants of the test mode configuration programmer
`ifndef TCP_DEFINES_VH
`define TCP_DEFINES_VH

`define TCP_WORD_W 58
`define TCP_LIM_W 6
`define TCP_MODE_W 4
`define TCP_PIN_N 5

// test mode numbers
`define TCP_T0 4'h0
`define TCP_T1 4'h1
`define TCP_T2 4'h2
`define TCP_T3 4'h3
`define TCP_T4 4'h4
`define TCP_T5 4'h5
`define TCP_T6 4'h6
`define TCP_T7 4'h7
`define TCP_T8 4'h8
`define TCP_T9 4'h9
`define TCP_T10 4'hA
`define TCP_T11 4'hB
`define TCP_T12 4'hC
`define TCP_T13 4'hD
`define TCP_T14 4'hE

// configuration word field positions
`define TCP_SETUP_HI 57
`define TCP_SETUP_LO 36
`define TCP_SETUP_W 22
`define TCP_LTD_EN_BIT 50
`define TCP_NL_HI 35
`define TCP_NL_LO 30
`define TCP_HYL_HI 29
`define TCP_HYL_LO 24
`define TCP_HUL_HI 23
`define TCP_HUL_LO 18
`define TCP_CTL_HI 17
`define TCP_CTL_LO 12
`define TCP_NAM_HI 11
`define TCP_NAM_LO 6
`define TCP_BASE_HI 5
`define TCP_BASE_LO 0

`define TCP_CONFIG_RESET 58'h000_0000_0000_0000

`endif

// ==== tcp_sync.v ====
// two flip-flop synchroniser, one stage pair per bit
`timescale 1ns/100ps
`default_nettype none
module tcp_sync #(
    parameter WIDTH = 5
) (
    input wire ref_clk_i,
    input wire rst_n_i,
    input wire [WIDTH-1:0] async_i,
    output wire [WIDTH-1:0] sync_o
);
    genvar gi;
    generate
        for (gi = 0; gi < WIDTH; gi = gi + 1) begin : g_bit
            reg meta;
            reg stable;
            always @(posedge ref_clk_i) begin
                if (!rst_n_i) begin
                    meta <= 1'b0;
                    stable <= 1'b0;
                end else begin
                    meta <= async_i[gi];
                    stable <= meta;
                end
            end
            assign sync_o[gi] = stable;
        end
    endgenerate
endmodule // tcp_sync
`default_nettype wire

// ==== tcp_buf2.v ====
// two-entry valid/ready buffer
`timescale 1ns/100ps
`default_nettype none
module tcp_buf2 #(
    parameter WIDTH = 1
) (
    input wire ref_clk_i,
    input wire rst_n_i,
    input wire in_valid_i,
    output wire in_ready_o,
    input wire [WIDTH-1:0] in_data_i,
    output wire out_valid_o,
    input wire out_ready_i,
    output wire [WIDTH-1:0] out_data_o
);
    reg [WIDTH-1:0] slot0;
    reg [WIDTH-1:0] slot1;
    reg [1:0] count;
    wire push = in_valid_i && (count != 2'h2);
    wire pop = out_ready_i && (count != 2'h0);

    assign in_ready_o = (count != 2'h2);
    assign out_valid_o = (count != 2'h0);
    assign out_data_o = slot0;

    always @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            slot0 <= {WIDTH{1'b0}};
            slot1 <= {WIDTH{1'b0}};
            count <= 2'h0;
        end else begin
            case ({push, pop})
                2'b10: begin
                    if (count == 2'h0) begin
                        slot0 <= in_data_i;
                    end else begin
                        slot1 <= in_data_i;
                    end
                    count <= count + 2'h1;
                end
                2'b01: begin
                    slot0 <= slot1;
                    count <= count - 2'h1;
                end
                2'b11: begin
                    if (count == 2'h1) begin
                        slot0 <= in_data_i;
                    end else begin
                        slot0 <= slot1;
                        slot1 <= in_data_i;
                    end
                end
                default: begin
                    count <= count;
                end
            endcase
        end
    end
endmodule // tcp_buf2
`default_nettype wire

// ==== tcp_config_programmer.v ====
// test mode stepping, limit latching and configuration word programming
`include "tcp_defines.vh"
`timescale 1ns/100ps
`default_nettype none

module tcp_config_programmer (
    input wire ref_clk_i,
    input wire rst_n_i,
    input wire mode_entry_pin_i,
    input wire test_boost_i,
    input wire test_data_i,
    input wire feed_i,
    input wire io_i,
    input wire [5:0] dac_level_i,
    input wire [5:0] integrator_output_i,
    input wire [5:0] measured_value_i,
    input wire measure_done_i,
    input wire low_battery_result_i,
    output reg horn_b_output_o,
    output reg red_indicator_o,
    output reg green_indicator_o,
    output reg horn_sync_error_flag_o,
    output reg integrate_start_o,
    output reg measure_start_o,
    output reg boost_enable_o,
    output reg nv_write_o,
    output reg [57:0] nv_word_o,
    output reg [3:0] test_mode_o,
    output reg shift_ready_o
);
    // ---------------------------------------------------------------
    // commit sequence states
    // ---------------------------------------------------------------
    localparam [1:0] ST_LATCH = 2'b01;
    localparam [1:0] ST_STORE = 2'b10;

    // ---------------------------------------------------------------
    // pin synchronisation and edges
    // ---------------------------------------------------------------
    wire [4:0] pins_raw;
    wire [4:0] pins_s;
    reg [4:0] pins_d;

    assign pins_raw = {mode_entry_pin_i, test_boost_i, test_data_i, feed_i, io_i};

    tcp_sync #(
        .WIDTH(`TCP_PIN_N)
    ) u_sync (
        .ref_clk_i(ref_clk_i),
        .rst_n_i(rst_n_i),
        .async_i(pins_raw),
        .sync_o(pins_s)
    );

    wire entry = pins_s[4];
    wire test_data = pins_s[2];
    wire feed = pins_s[1];
    wire io = pins_s[0];
    wire test_clk_rise = pins_s[3] & ~pins_d[3];
    wire feed_rise = pins_s[1] & ~pins_d[1];
    wire io_rise = pins_s[0] & ~pins_d[0];
    wire io_fall = ~pins_s[0] & pins_d[0];

    // ---------------------------------------------------------------
    // state
    // ---------------------------------------------------------------
    reg [3:0] mode;
    // image of the stored word; limit checks and readback start from it
    reg [57:0] cfg_word;
    reg [57:0] shreg;
    reg [5:0] lim_nl;
    reg [5:0] lim_hyl;
    reg [5:0] lim_hul;
    reg [5:0] lim_ctl;
    reg [5:0] lim_nam;
    reg [4:0] pend;
    reg [1:0] commit_st;
    reg [5:0] meas_val;
    reg meas_valid;
    reg meas_busy;

    wire in_t0 = entry && (mode == `TCP_T0);
    wire in_t1 = entry && (mode == `TCP_T1);
    wire in_t2 = entry && (mode == `TCP_T2);
    wire in_t7 = entry && (mode == `TCP_T7);
    wire in_t8 = entry && (mode == `TCP_T8);
    wire in_t9 = entry && (mode == `TCP_T9);
    wire in_set = entry && (mode >= `TCP_T3) && (mode <= `TCP_T7);
    wire in_meas = entry && (mode >= `TCP_T9) && (mode <= `TCP_T14);
    wire in_chk = entry && (mode >= `TCP_T10) && (mode <= `TCP_T14);
    wire in_shift = in_t2 || in_t8;

    // ---------------------------------------------------------------
    // serial bit buffer
    // ---------------------------------------------------------------
    wire buf_in_ready;
    wire buf_out_valid;
    wire buf_out_data;
    // shifting pauses while a store is taken so the stored word is stable
    wire buf_out_ready = ~io_rise;
    wire bit_pop = buf_out_valid && buf_out_ready;

    tcp_buf2 #(
        .WIDTH(1)
    ) u_buf (
        .ref_clk_i(ref_clk_i),
        .rst_n_i(rst_n_i),
        .in_valid_i(feed_rise && in_shift),
        .in_ready_o(buf_in_ready),
        .in_data_i(test_data),
        .out_valid_o(buf_out_valid),
        .out_ready_i(buf_out_ready),
        .out_data_o(buf_out_data)
    );

    // ---------------------------------------------------------------
    // candidate word and error checks
    // ---------------------------------------------------------------
    wire [5:0] m_nl = pend[0] ? lim_nl : cfg_word[`TCP_NL_HI:`TCP_NL_LO];
    wire [5:0] m_hyl = pend[1] ? lim_hyl : cfg_word[`TCP_HYL_HI:`TCP_HYL_LO];
    wire [5:0] m_hul = pend[2] ? lim_hul : cfg_word[`TCP_HUL_HI:`TCP_HUL_LO];
    wire [5:0] m_ctl = pend[3] ? lim_ctl : cfg_word[`TCP_CTL_HI:`TCP_CTL_LO];
    wire [5:0] m_nam = pend[4] ? lim_nam : cfg_word[`TCP_NAM_HI:`TCP_NAM_LO];
    wire [57:0] merged = {cfg_word[`TCP_SETUP_HI:`TCP_SETUP_LO], m_nl, m_hyl, m_hul, m_ctl,
                          m_nam, cfg_word[`TCP_BASE_HI:`TCP_BASE_LO]};

    reg [57:0] store_word;
    always @* begin
        if (in_t8) begin
            store_word = shreg;
        end else if (in_t2) begin
            store_word = {shreg[`TCP_SETUP_W-1:0], cfg_word[`TCP_NL_HI:0]};
        end else if (in_t9) begin
            // baseline replaces only the low field; limits stay as stored
            store_word = {cfg_word[`TCP_SETUP_HI:`TCP_NAM_LO], measured_value_i};
        end else begin
            store_word = merged;
        end
    end

    wire [5:0] e_nl = store_word[`TCP_NL_HI:`TCP_NL_LO];
    wire [5:0] e_hyl = store_word[`TCP_HYL_HI:`TCP_HYL_LO];
    wire [5:0] e_nam = store_word[`TCP_NAM_HI:`TCP_NAM_LO];
    wire err_hyst = (e_hyl >= e_nl);
    wire err_max = store_word[`TCP_LTD_EN_BIT] && (e_nam <= e_nl);
    wire err_mode = in_t7 || in_t8 || in_t9;
    wire err_set = io_fall && err_mode && (err_hyst || err_max);

    // ---------------------------------------------------------------
    // limit selected for checking
    // ---------------------------------------------------------------
    reg [5:0] chk_limit;
    always @* begin
        if (mode == `TCP_T10) begin
            chk_limit = cfg_word[`TCP_NL_HI:`TCP_NL_LO];
        end else if (mode == `TCP_T11) begin
            chk_limit = cfg_word[`TCP_HYL_HI:`TCP_HYL_LO];
        end else if (mode == `TCP_T12) begin
            chk_limit = cfg_word[`TCP_HUL_HI:`TCP_HUL_LO];
        end else if (mode == `TCP_T13) begin
            chk_limit = cfg_word[`TCP_CTL_HI:`TCP_CTL_LO];
        end else begin
            // last check mode, and the unused codes, fall back to the max limit
            chk_limit = cfg_word[`TCP_NAM_HI:`TCP_NAM_LO];
        end
    end

    // ---------------------------------------------------------------
    // store triggers
    // ---------------------------------------------------------------
    // in the shift modes every enable rise rewrites the same word, so repeated pulses are harmless
    wire store_shift = in_shift && io_rise;
    wire store_commit = in_t7 && io_rise && ~feed && (commit_st == ST_STORE);
    wire store_base = in_t9 && io_rise;
    wire do_store = store_shift || store_commit || store_base;
    // mode saturates at the last check mode instead of wrapping to horn test
    wire mode_step = entry && test_clk_rise && (mode != `TCP_T14);

    // ---------------------------------------------------------------
    // horn pin selection
    // ---------------------------------------------------------------
    reg next_horn;
    always @* begin
        // outside the listed modes the pin stays quiet
        next_horn = 1'b0;
        if (in_t0) begin
            next_horn = test_data;
        end else if (in_t1) begin
            next_horn = low_battery_result_i;
        end else if (in_set) begin
            next_horn = (dac_level_i < integrator_output_i);
        end else if (in_t8) begin
            next_horn = shreg[`TCP_WORD_W-1];
        end else if (in_chk) begin
            next_horn = meas_valid && (meas_val > chk_limit);
        end
    end

    // ---------------------------------------------------------------
    // main sequential logic
    // ---------------------------------------------------------------
    always @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            pins_d <= 5'h00;
            mode <= `TCP_T0;
            cfg_word <= `TCP_CONFIG_RESET;
            shreg <= `TCP_CONFIG_RESET;
            lim_nl <= 6'h00;
            lim_hyl <= 6'h00;
            lim_hul <= 6'h00;
            lim_ctl <= 6'h00;
            lim_nam <= 6'h00;
            pend <= 5'h00;
            commit_st <= ST_LATCH;
            meas_val <= 6'h00;
            meas_valid <= 1'b0;
            meas_busy <= 1'b0;
            horn_b_output_o <= 1'b0;
            red_indicator_o <= 1'b0;
            green_indicator_o <= 1'b0;
            horn_sync_error_flag_o <= 1'b0;
            integrate_start_o <= 1'b0;
            measure_start_o <= 1'b0;
            boost_enable_o <= 1'b0;
            nv_write_o <= 1'b0;
            nv_word_o <= `TCP_CONFIG_RESET;
            test_mode_o <= `TCP_T0;
            shift_ready_o <= 1'b0;
        end else begin
            pins_d <= pins_s;
            horn_b_output_o <= next_horn;
            red_indicator_o <= in_t1;
            green_indicator_o <= in_t1;
            boost_enable_o <= in_t1 && io;
            integrate_start_o <= in_set && feed && io_rise;
            measure_start_o <= in_meas && feed_rise;
            test_mode_o <= mode;
            shift_ready_o <= buf_in_ready && in_shift;
            nv_write_o <= do_store;

            if (!entry) begin
                // leaving programming drops everything unstored
                mode <= `TCP_T0;
                pend <= 5'h00;
                commit_st <= ST_LATCH;
                meas_valid <= 1'b0;
                meas_busy <= 1'b0;
                horn_sync_error_flag_o <= 1'b0;
            end else begin
                if (mode_step) begin
                    mode <= mode + 4'h1;
                    commit_st <= ST_LATCH;
                    meas_valid <= 1'b0;
                    meas_busy <= 1'b0;
                    horn_sync_error_flag_o <= 1'b0;
                    if (mode == `TCP_T1) begin
                        shreg <= `TCP_CONFIG_RESET;
                    end else if (mode == `TCP_T7) begin
                        // readback starts from the stored word
                        shreg <= cfg_word;
                    end
                end else if (bit_pop && in_shift) begin
                    shreg <= {shreg[`TCP_WORD_W-2:0], buf_out_data};
                end

                // set wins over the mode-exit clear
                if (err_set) begin
                    horn_sync_error_flag_o <= 1'b1;
                end

                if (in_set && !feed && io_rise) begin
                    if (mode == `TCP_T3) begin
                        lim_nl <= dac_level_i;
                        pend[0] <= 1'b1;
                    end else if (mode == `TCP_T4) begin
                        lim_hyl <= dac_level_i;
                        pend[1] <= 1'b1;
                    end else if (mode == `TCP_T5) begin
                        lim_hul <= dac_level_i;
                        pend[2] <= 1'b1;
                    end else if (mode == `TCP_T6) begin
                        lim_ctl <= dac_level_i;
                        pend[3] <= 1'b1;
                    end else begin
                        case (commit_st)
                            ST_LATCH: begin
                                lim_nam <= dac_level_i;
                                pend[4] <= 1'b1;
                                commit_st <= ST_STORE;
                            end
                            ST_STORE: begin
                                pend <= 5'h00;
                                commit_st <= ST_LATCH;
                            end
                            default: begin
                                commit_st <= ST_LATCH;
                            end
                        endcase
                    end
                end

                // a new start hides the old result until its own done arrives
                if (in_meas && feed_rise) begin
                    meas_busy <= 1'b1;
                    meas_valid <= 1'b0;
                end else if (meas_busy && measure_done_i) begin
                    meas_busy <= 1'b0;
                    meas_valid <= 1'b1;
                    meas_val <= measured_value_i;
                end
            end

            if (do_store) begin
                cfg_word <= store_word;
                nv_word_o <= store_word;
            end
        end
    end
endmodule // tcp_config_programmer
`default_nettype wire

// ==== tcp_config_programmer_monitor.sv ====
// port assertions for the test mode configuration programmer
`timescale 1ns/100ps
`default_nettype none
module tcp_config_programmer_monitor (
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire logic mode_entry_pin_i,
    input wire logic horn_sync_error_flag_o,
    input wire logic red_indicator_o,
    input wire logic green_indicator_o,
    input wire logic integrate_start_o,
    input wire logic measure_start_o,
    input wire logic boost_enable_o,
    input wire logic nv_write_o,
    input wire logic [57:0] nv_word_o,
    input wire logic [3:0] test_mode_o,
    input wire logic shift_ready_o
);
    logic [35:0] prev_low;
    // ----
    // last stored low bits
    // ----
    always @(posedge ref_clk_i) begin
        prev_low <= nv_word_o[35:0];
    end
    default clocking mon_cb @(posedge ref_clk_i);
    endclocking
    default disable iff (!rst_n_i);
    // mode output lags by a cycle, so both neighbours are accepted
    leds_in_t1_a: assert property ((red_indicator_o || green_indicator_o)
        |-> ##[0:1] (test_mode_o == 4'h1 || $past(test_mode_o) == 4'h1)) else $error("led lit");
    boost_in_t1_a: assert property (boost_enable_o
        |-> ##[0:1] (test_mode_o == 4'h1 || $past(test_mode_o) == 4'h1)) else $error("boost on");
    flag_modes_a: assert property (horn_sync_error_flag_o |-> ##[0:1]
        (test_mode_o inside {[4'h7:4'h9]} || $past(test_mode_o) inside {[4'h7:4'h9]}))
        else $error("error flag outside its modes");
    flag_hold_a: assert property ($fell(horn_sync_error_flag_o)
        |-> ##[1:3] test_mode_o != $past(test_mode_o, 3)) else $error("error flag dropped");
    entry_clear_a: assert property (!mode_entry_pin_i [*8]
        |-> test_mode_o == 4'h0 && !horn_sync_error_flag_o) else $error("entry low kept state");
    nv_pulse_a: assert property (nv_write_o |=> !nv_write_o)
        else $error("store pulse too long");
    setup_keep_a: assert property (nv_write_o && test_mode_o == 4'h2
        |-> nv_word_o[35:0] == prev_low) else $error("setup store touched limits");
    integ_mode_a: assert property (integrate_start_o
        |-> test_mode_o inside {[4'h3:4'h7]} ##1 !integrate_start_o) else $error("bad integrate");
    meas_mode_a: assert property (measure_start_o
        |-> test_mode_o inside {[4'h9:4'hE]}) else $error("measure start outside checks");
    ready_mode_a: assert property (shift_ready_o
        |-> ##[0:2] (test_mode_o == 4'h2 || test_mode_o == 4'h8)) else $error("ready outside");
endmodule // tcp_config_programmer_monitor
bind tcp_config_programmer tcp_config_programmer_monitor u_monitor (.ref_clk_i, .rst_n_i,
    .mode_entry_pin_i, .horn_sync_error_flag_o, .red_indicator_o, .green_indicator_o,
    .integrate_start_o, .measure_start_o, .boost_enable_o, .nv_write_o, .nv_word_o,
    .test_mode_o, .shift_ready_o);
`default_nettype wire

// ==== tcp_prog_model.sv ====
// programmer fixture model driving the five test pins
`timescale 1ns/100ps
`default_nettype none
module tcp_prog_model (
    input wire logic ref_clk_i,
    input wire logic serial_i,
    output logic entry_o,
    output logic boost_o,
    output logic data_o,
    output logic feed_o,
    output logic io_o
);
    initial begin
        {entry_o, boost_o, data_o, feed_o, io_o} = 5'h00;
    end
    // ----
    // link half period, 100 ns
    // ----
    task automatic half();
        repeat (4) @(negedge ref_clk_i);
    endtask
    // dropping entry is the only way back to the horn test mode
    task automatic set_pins(input logic entry, input logic data);
        entry_o = entry;
        data_o = data;
        half();
        half();
    endtask
    task automatic test_clock();
        boost_o = 1'b1;
        half();
        boost_o = 1'b0;
        half();
    endtask
    // serial out is read before the feed rise moves it
    task automatic shift_bit(input logic b, output logic s);
        data_o = b;
        feed_o = 1'b0;
        half();
        s = serial_i;
        feed_o = 1'b1;
        // data turns over mid-phase so a late sample would be caught
        repeat (2) @(negedge ref_clk_i);
        data_o = ~b;
        repeat (2) @(negedge ref_clk_i);
    endtask
    // feed level picks integrate or latch; repeated for commit
    task automatic pulse_io(input logic feed);
        feed_o = feed;
        io_o = 1'b1;
        half();
        io_o = 1'b0;
        half();
    endtask
    task automatic set_io(input logic level);
        io_o = level;
        half();
        half();
    endtask
endmodule // tcp_prog_model
`default_nettype wire

// ==== testbench.sv ====
// self-checking bench for the test mode configuration programmer
`timescale 1ns/100ps
`default_nettype none
module testbench;
    typedef struct packed {
        logic [3:0] mode;
        logic io;
        logic [5:0] dac;
        logic [5:0] integ;
        logic lowbat;
        logic horn;
        logic boost;
    } tcp_row_t;
    localparam logic [21:0] setup_bits = 22'h02A3C5;
    localparam logic [57:0] word7 = {setup_bits, 6'h14, 6'h14, 6'h0A, 6'h05, 6'h30, 6'h00};
    localparam logic [57:0] word8 = {setup_bits | 22'h004000, 6'h14, 6'h05, 12'h000, 6'h14, 6'h00};
    logic ref_clk_i, rst_n_i, entry, boost, tdata, feed, io, done, lowbat, s;
    logic [5:0] dac, integ, meas;
    logic horn, red, green, flag, integ_start, meas_start, boost_en, nv_write, ready;
    logic [57:0] nv_word;
    logic [3:0] mode;
    int num_errors = 0;
    int compares = 0;
    int nv_cnt = 0;
    int integ_cnt = 0;
    int meas_cnt = 0;
    int done_wait = 0;
    tcp_row_t rows [6] = '{
        '{4'h1, 1'b0, 6'h00, 6'h00, 1'b1, 1'b1, 1'b0},
        '{4'h1, 1'b1, 6'h00, 6'h00, 1'b0, 1'b0, 1'b1},
        '{4'h1, 1'b1, 6'h00, 6'h00, 1'b1, 1'b1, 1'b1},
        '{4'h3, 1'b0, 6'h0A, 6'h0B, 1'b0, 1'b1, 1'b0},
        '{4'h3, 1'b0, 6'h0B, 6'h0A, 1'b0, 1'b0, 1'b0},
        '{4'h3, 1'b0, 6'h00, 6'h3F, 1'b0, 1'b1, 1'b0}};
    tcp_config_programmer dut (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
        .mode_entry_pin_i(entry), .test_boost_i(boost), .test_data_i(tdata), .feed_i(feed),
        .io_i(io), .dac_level_i(dac), .integrator_output_i(integ), .measured_value_i(meas),
        .measure_done_i(done), .low_battery_result_i(lowbat), .horn_b_output_o(horn),
        .red_indicator_o(red), .green_indicator_o(green), .horn_sync_error_flag_o(flag),
        .integrate_start_o(integ_start), .measure_start_o(meas_start),
        .boost_enable_o(boost_en), .nv_write_o(nv_write), .nv_word_o(nv_word),
        .test_mode_o(mode), .shift_ready_o(ready));
    tcp_prog_model prog (.ref_clk_i(ref_clk_i), .serial_i(horn), .entry_o(entry),
        .boost_o(boost), .data_o(tdata), .feed_o(feed), .io_o(io));
    initial begin
        ref_clk_i = 1'b0;
        forever #12.5 ref_clk_i = ~ref_clk_i;
    end
    always @(posedge ref_clk_i) begin
        if (nv_write === 1'b1) nv_cnt <= nv_cnt + 1;
        if (integ_start === 1'b1) integ_cnt <= integ_cnt + 1;
        if (meas_start === 1'b1) meas_cnt <= meas_cnt + 1;
    end
    // measurement finishes a fixed while after each start
    always @(negedge ref_clk_i) begin
        done <= (done_wait == 1);
        if (meas_start === 1'b1) done_wait <= 12;
        else if (done_wait > 0) done_wait <= done_wait - 1;
    end
    // ----
    // shared tasks
    // ----
    task automatic results();
        if (num_errors == 0 && compares > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic check(input logic [57:0] seen, input logic [57:0] exp_v);
        compares++;
        if (seen !== exp_v) begin
            num_errors++;
            $display("BAD t=%0t seen=%h expected=%h", $time, seen, exp_v);
        end
    endtask
    // bounded stepping: a mode that never shows up ends the run
    task automatic goto(input logic [3:0] target);
        for (int n = 0; n < 16 && mode !== target; n++) prog.test_clock();
        if (mode !== target) begin
            num_errors++;
            results();
        end
    endtask
    task automatic limit(input logic [3:0] m, input logic [5:0] v);
        goto(m);
        dac = v;
        prog.pulse_io(1'b0);
    endtask
    // ----
    // main sequence
    // ----
    initial begin
        rst_n_i = 1'b0;
        {dac, integ, meas, lowbat} = 19'h00000;
        repeat (16) @(negedge ref_clk_i);
        rst_n_i = 1'b1;
        repeat (4) @(negedge ref_clk_i);
        check(mode, 4'h0);
        check(nv_word, 58'h0);
        prog.set_pins(1'b1, 1'b1);
        check(horn, 1'b1);
        prog.set_pins(1'b0, 1'b1);
        check(horn, 1'b0);
        prog.set_pins(1'b1, 1'b0);
        goto(4'h1);
        check({red, green}, 2'h3);
        for (int i = 0; i < 6; i++) begin
            goto(rows[i].mode);
            dac = rows[i].dac;
            integ = rows[i].integ;
            lowbat = rows[i].lowbat;
            prog.set_io(rows[i].io);
            check(horn, rows[i].horn);
            check(boost_en, rows[i].boost);
        end
        prog.set_pins(1'b0, 1'b0);
        check(mode, 4'h0);
        prog.set_pins(1'b1, 1'b0);
        goto(4'h2);
        check(ready, 1'b1);
        for (int i = 21; i >= 0; i--) prog.shift_bit(setup_bits[i], s);
        repeat (2) prog.pulse_io(1'b0);
        check(nv_cnt, 2);
        check(nv_word, {setup_bits, 36'h0});
        goto(4'h3);
        prog.pulse_io(1'b1);
        check(integ_cnt, 1);
        limit(4'h3, 6'h14);
        limit(4'h4, 6'h14);
        limit(4'h5, 6'h0A);
        limit(4'h6, 6'h05);
        check(nv_cnt, 2);
        limit(4'h7, 6'h30);
        prog.pulse_io(1'b0);
        repeat (4) @(negedge ref_clk_i);
        check(nv_cnt, 3);
        check(nv_word, word7);
        check(flag, 1'b1);
        goto(4'h8);
        check(flag, 1'b0);
        for (int i = 57; i >= 0; i--) begin
            prog.shift_bit(word8[i], s);
            check(s, word7[i]);
        end
        prog.pulse_io(1'b0);
        repeat (4) @(negedge ref_clk_i);
        check(nv_word, word8);
        check(flag, 1'b1);
        goto(4'h9);
        meas = 6'h11;
        prog.pulse_io(1'b0);
        repeat (4) @(negedge ref_clk_i);
        check(nv_word, {word8[57:6], 6'h11});
        check(flag, 1'b1);
        goto(4'hA);
        check(flag, 1'b0);
        // second pass proves the start clears the previous result
        for (int i = 0; i < 2; i++) begin
            prog.shift_bit(1'b0, s);
            repeat (4) @(negedge ref_clk_i);
            check(horn, 1'b0);
            meas = 6'h15 - i[5:0];
            repeat (12) @(negedge ref_clk_i);
            check(horn, meas > 6'h14);
        end
        check(meas_cnt, 2);
        results();
    end
endmodule // testbench
`default_nettype wire
